//--- bench/tb_top.sv
// Self-checking bench for the extended memory ALU behind its APB slave
// Assumes emao_top and emao_pkg; the bench drives the APB port directly
`timescale 1ns/10ps
module tb_top;
   import emao_pkg::*;
   typedef struct packed {
      logic [4:0] op;
      logic [7:0] acc;
      logic [5:0] flg;
      logic [7:0] mem;
      logic [7:0] eacc;
      logic [5:0] eflg;
      logic [7:0] emem;
   } emao_row_type;
   logic ref_clk_in = 1'b0;
   logic reset_in = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [31:0] rd;
   logic er;
   int err_total = 0;
   int checks_done = 0;
   emao_row_type rows [0:29];

   emao_top i_emao_top (
      .ref_clk_in(ref_clk_in),
      .reset_in(reset_in),
      .psel_in(psel),
      .penable_in(penable),
      .pwrite_in(pwrite),
      .paddr_in(paddr),
      .pwdata_in(pwdata),
      .prdata_out(prdata),
      .pready_out(pready),
      .pslverr_out(pslverr)
   );

   always #2.5 ref_clk_in = ~ref_clk_in;

   task results();
      if (err_total == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
         err_total++;
      end
   endtask

   // One transfer, entered just after a rising edge; left with psel high
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk_in);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk_in);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         err_total++;
         results();
      end else begin
         rd = prdata;
         er = pslverr;
      end
   endtask

   task rchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask

   task idle();
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk_in);
   endtask

   initial begin
      // op, acc, flags, mem, expected acc, flags, mem
      rows = '{
         '{5'h01, 8'h12, 6'h00, 8'h0f, 8'h12, 6'h00, 8'hf0},
         '{5'h01, 8'h12, 6'h3b, 8'hff, 8'h12, 6'h3f, 8'h00},
         '{5'h02, 8'h00, 6'h04, 8'ha5, 8'h5a, 6'h00, 8'ha5},
         '{5'h03, 8'h3c, 6'h00, 8'h55, 8'h3c, 6'h00, 8'h42},
         '{5'h03, 8'ha3, 6'h02, 8'h55, 8'ha3, 6'h03, 8'h09},
         '{5'h03, 8'h45, 6'h01, 8'h55, 8'h45, 6'h01, 8'ha5},
         '{5'h03, 8'h12, 6'h00, 8'h55, 8'h12, 6'h00, 8'h12},
         '{5'h04, 8'h77, 6'h00, 8'h01, 8'h77, 6'h04, 8'h00},
         '{5'h04, 8'h77, 6'h04, 8'h00, 8'h77, 6'h00, 8'hff},
         '{5'h05, 8'h00, 6'h00, 8'h80, 8'h7f, 6'h00, 8'h80},
         '{5'h06, 8'h00, 6'h00, 8'hff, 8'h00, 6'h04, 8'h00},
         '{5'h07, 8'h00, 6'h04, 8'h41, 8'h42, 6'h00, 8'h41},
         '{5'h08, 8'h33, 6'h3f, 8'h00, 8'h00, 6'h3f, 8'h00},
         '{5'h09, 8'hc3, 6'h00, 8'h11, 8'hc3, 6'h00, 8'hc3},
         '{5'h0a, 8'h00, 6'h00, 8'h00, 8'h00, 6'h04, 8'h00},
         '{5'h0a, 8'h50, 6'h04, 8'h05, 8'h55, 6'h00, 8'h05},
         '{5'h0b, 8'h0f, 6'h04, 8'hf0, 8'h0f, 6'h00, 8'hff},
         '{5'h0c, 8'h00, 6'h00, 8'h81, 8'h00, 6'h00, 8'h03},
         '{5'h0d, 8'h00, 6'h3f, 8'h40, 8'h80, 6'h3f, 8'h40},
         '{5'h0e, 8'h00, 6'h00, 8'h80, 8'h00, 6'h01, 8'h00},
         '{5'h0f, 8'h00, 6'h01, 8'h01, 8'h03, 6'h00, 8'h01},
         '{5'h10, 8'h00, 6'h00, 8'h01, 8'h00, 6'h00, 8'h80},
         '{5'h11, 8'h00, 6'h00, 8'h02, 8'h01, 6'h00, 8'h02},
         '{5'h12, 8'h00, 6'h00, 8'h01, 8'h00, 6'h01, 8'h00},
         '{5'h13, 8'h00, 6'h01, 8'h02, 8'h81, 6'h00, 8'h02},
         '{5'h14, 8'h05, 6'h01, 8'h03, 8'h02, 6'h03, 8'h03},
         '{5'h14, 8'h05, 6'h21, 8'h05, 8'h00, 6'h27, 8'h05},
         '{5'h14, 8'h00, 6'h00, 8'h00, 8'hff, 6'h10, 8'h00},
         '{5'h14, 8'h80, 6'h01, 8'h01, 8'h7f, 6'h19, 8'h01},
         '{5'h15, 8'h10, 6'h01, 8'h20, 8'h10, 6'h12, 8'hf0}};
      repeat (12) @(posedge ref_clk_in);
      reset_in <= 1'b0;
      @(posedge ref_clk_in);
      for (int i = 0; i < 30; i++) begin
         apb(1'b1, OFS_MADDR, {21'h0, 11'(i * 73)});
         apb(1'b1, OFS_MDATA, {24'h0, rows[i].mem});
         apb(1'b1, OFS_ACC, {24'h0, rows[i].acc});
         apb(1'b1, OFS_FLAGS, {26'h0, rows[i].flg});
         apb(1'b1, OFS_CMD, {27'h0, rows[i].op});
         rchk(OFS_ACC, {24'h0, rows[i].eacc}); // Acc
         rchk(OFS_FLAGS, {26'h0, rows[i].eflg}); // Flags
         rchk(OFS_MDATA, {24'h0, rows[i].emem}); // Byte
      end
      // Lowest and highest byte reached without any bank select
      apb(1'b1, OFS_MADDR, 32'h7ff);
      apb(1'b1, OFS_MDATA, 32'haa);
      apb(1'b1, OFS_MADDR, 32'h000);
      apb(1'b1, OFS_MDATA, 32'h55);
      apb(1'b1, OFS_MADDR, 32'h7ff);
      apb(1'b1, OFS_CMD, {27'h0, OP_EXT_INCREMENT_MEM});
      rchk(OFS_MDATA, 32'hab); // Top byte
      apb(1'b1, OFS_MADDR, 32'h000);
      rchk(OFS_MDATA, 32'h55); // Bottom byte kept
      // Field widths of flags and address
      apb(1'b1, OFS_FLAGS, 32'hffffffff);
      rchk(OFS_FLAGS, 32'h3f); // Flags width
      apb(1'b1, OFS_MADDR, 32'hffffffff);
      rchk(OFS_MADDR, 32'h7ff); // Address width
      // Unknown code only sets the mark; a legal one clears it
      apb(1'b1, OFS_ACC, 32'h5a);
      apb(1'b1, OFS_CMD, 32'h16);
      chk({31'h0, er}, 32'h0);
      apb(1'b0, OFS_CMD, 32'h0);
      chk({31'h0, rd[8]}, 32'h1);
      rchk(OFS_ACC, 32'h5a);
      apb(1'b1, OFS_CMD, {27'h0, OP_EXT_MOVE_TO_ACC});
      rchk(OFS_CMD, 32'h08); // Op kept, mark cleared
      rchk(OFS_ACC, 32'hab); // Move from top byte
      // Unmapped read and write report an error
      apb(1'b0, 8'h14, 32'h0);
      chk({31'h0, er}, 32'h1);
      chk(rd, 32'h0);
      apb(1'b1, 8'h20, 32'h1234);
      chk({31'h0, er}, 32'h1);
      // Leave the bad-code mark set so reset must clear it
      apb(1'b1, OFS_CMD, 32'h1f);
      rchk(OFS_CMD, 32'h108); // Mark set, last op kept
      // Reset in mid-run clears the registers
      idle();
      reset_in <= 1'b1;
      repeat (2) @(posedge ref_clk_in);
      reset_in <= 1'b0;
      @(posedge ref_clk_in);
      rchk(OFS_ACC, 32'h0);
      rchk(OFS_FLAGS, 32'h0);
      rchk(OFS_MADDR, 32'h0);
      rchk(OFS_CMD, 32'h0);
      idle();
      results();
   end
endmodule

//--- rtl/emao_data_mem.sv
// Byte-wide data memory with a registered read port
// Assumes one clock; a read of a byte being written returns the old value
`timescale 1ns/10ps
module emao_data_mem (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic reset_in,
   // Memory port
   input wire logic we_in,
   input wire logic [emao_pkg::MEM_AW-1:0] addr_in,
   input wire logic [7:0] wdata_in,
   output logic [7:0] rdata_out
);
   import emao_pkg::*;

   logic [7:0] mem_r [MEM_DEPTH];
   logic [7:0] rdata_r;

   always_ff @(posedge ref_clk_in) begin
      if (we_in) begin
         mem_r[addr_in] <= wdata_in;
      end
   end

   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         rdata_r <= 8'h00;
      end else begin
         rdata_r <= mem_r[addr_in];
      end
   end

   assign rdata_out = rdata_r;
endmodule

//--- rtl/emao_pkg.sv
// Constants, opcodes, state and register types of the extended memory ALU
// Assumes an APB slave with 32-bit data and a byte-wide data memory
package emao_pkg;
   // Bus and memory geometry
   localparam int PADDR_W = 8;
   localparam int PDATA_W = 32;
   localparam int MEM_AW = 11;
   localparam int MEM_DEPTH = 2048;
   // Register byte offsets
   localparam logic [7:0] OFS_ACC = 8'h00;
   localparam logic [7:0] OFS_FLAGS = 8'h04;
   localparam logic [7:0] OFS_MADDR = 8'h08;
   localparam logic [7:0] OFS_MDATA = 8'h0c;
   localparam logic [7:0] OFS_CMD = 8'h10;
   // Status flag positions
   localparam int FLAGS_W = 6;
   localparam int FLG_C = 0;
   localparam int FLG_AC = 1;
   localparam int FLG_Z = 2;
   localparam int FLG_OV = 3;
   localparam int FLG_SC = 4;
   localparam int FLG_CZ = 5;
   localparam logic [5:0] C_MASK = 6'h01;
   // Command register fields
   localparam int OP_W = 5;
   localparam int CMD_BAD_BIT = 8;
   // Reset values
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic [5:0] FLAGS_RST = 6'h00;
   localparam logic [10:0] MADDR_RST = 11'h000;
   localparam logic [4:0] OP_RST = 5'h00;
   // Decimal adjust
   localparam logic [3:0] BCD_LIMIT = 4'h9;
   localparam logic [3:0] BCD_FIX = 4'h6;
   // Command codes
   localparam logic [4:0] OP_EXT_INVERT_MEM = 5'h01;
   localparam logic [4:0] OP_EXT_INVERT_TO_ACC = 5'h02;
   localparam logic [4:0] OP_EXT_BCD_ADJUST_TO_MEM = 5'h03;
   localparam logic [4:0] OP_EXT_DECREMENT_MEM = 5'h04;
   localparam logic [4:0] OP_EXT_DECREMENT_TO_ACC = 5'h05;
   localparam logic [4:0] OP_EXT_INCREMENT_MEM = 5'h06;
   localparam logic [4:0] OP_EXT_INCREMENT_TO_ACC = 5'h07;
   localparam logic [4:0] OP_EXT_MOVE_TO_ACC = 5'h08;
   localparam logic [4:0] OP_EXT_MOVE_TO_MEM = 5'h09;
   localparam logic [4:0] OP_EXT_OR_TO_ACC = 5'h0a;
   localparam logic [4:0] OP_EXT_OR_TO_MEM = 5'h0b;
   localparam logic [4:0] OP_EXT_ROTATE_LEFT = 5'h0c;
   localparam logic [4:0] OP_EXT_ROTATE_LEFT_TO_ACC = 5'h0d;
   localparam logic [4:0] OP_EXT_ROTATE_LEFT_THRU_CARRY = 5'h0e;
   localparam logic [4:0] OP_EXT_ROTATE_LEFT_THRU_CARRY_TO_ACC = 5'h0f;
   localparam logic [4:0] OP_EXT_ROTATE_RIGHT = 5'h10;
   localparam logic [4:0] OP_EXT_ROTATE_RIGHT_TO_ACC = 5'h11;
   localparam logic [4:0] OP_EXT_ROTATE_RIGHT_THRU_CARRY = 5'h12;
   localparam logic [4:0] OP_EXT_ROTATE_RIGHT_THRU_CARRY_TO_ACC = 5'h13;
   localparam logic [4:0] OP_EXT_SUB_BORROW_TO_ACC = 5'h14;
   localparam logic [4:0] OP_EXT_SUB_BORROW_TO_MEM = 5'h15;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_RDWAIT,
      ST_FETCH,
      ST_EXEC
   } emao_state_type;

   typedef struct packed {
      emao_state_type st;
      logic [7:0] acc;
      logic [FLAGS_W-1:0] flags;
      logic [MEM_AW-1:0] addr;
      logic [OP_W-1:0] op;
      logic bad;
      logic pready;
      logic pslverr;
      logic [PDATA_W-1:0] prdata;
   } emao_regs_type;
endpackage

//--- rtl/emao_top.sv
// Extended memory ALU: APB registers, data memory and byte datapath
// Assumes an APB master on the same 200 MHz clock, no synchronisers needed
`timescale 1ns/10ps
// How it works
// - Any memory byte is reached by a full flat address, no bank select.
// - Invert memory writes the complemented byte back, changes only zero.
// - Invert to accumulator loads the complement, memory kept, zero updated.
// - Decimal adjust adds six per nibble above nine or with its carry.
// - Decimal adjust stores accumulator plus 00, 06, 60 or 66 in memory.
// - Decimal adjust alters only carry, set when the high nibble is above nine or carry was already set.
// - Decrement subtracts one into memory or accumulator, zero updated.
// - Increment adds one into memory or accumulator, zero updated.
// - Move to accumulator copies the byte, all flags untouched.
// - Move to memory copies the accumulator, all flags untouched.
// - OR of accumulator and byte goes to accumulator or memory, zero updated.
// - Rotate left wraps bit 7 into bit 0, no flags change.
// - Rotate left through carry: bit 7 to carry, carry to bit 0.
// - Rotate right wraps bit 0 into bit 7, no flags change.
// - Rotate right through carry: bit 0 to carry, carry to bit 7.
// - Subtract with borrow into accumulator, all six arithmetic flags.
// - Memory form of subtract with borrow stores difference in memory.
// - After subtract, carry is 0 for negative, 1 for zero or positive.
module emao_top (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic reset_in,
   // APB slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [emao_pkg::PADDR_W-1:0] paddr_in,
   input wire logic [emao_pkg::PDATA_W-1:0] pwdata_in,
   output logic [emao_pkg::PDATA_W-1:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out
);
   import emao_pkg::*;

   emao_regs_type s_r;
   emao_regs_type s_nxt;
   logic [7:0] mem_rd;
   logic [7:0] mem_wdata;
   logic [MEM_AW-1:0] mem_addr;
   logic mem_we;
   logic [OP_W-1:0] op;
   logic cin;
   logic ex;
   logic apb_acc;
   logic lo_adj;
   logic hi_adj;
   logic [7:0] bcd_corr;
   logic [8:0] bcd9;
   logic [8:0] sub9;
   logic [4:0] sub5;
   logic sub_ov;
   logic [7:0] res;
   logic [FLAGS_W-1:0] fl;
   logic to_mem;

   function automatic logic is_zero(input logic [7:0] v);
      return v == 8'h00;
   endfunction

   function automatic logic is_legal(input logic [OP_W-1:0] code);
      return code >= OP_EXT_INVERT_MEM && code <= OP_EXT_SUB_BORROW_TO_MEM;
   endfunction

   emao_data_mem u_mem (
      .ref_clk_in(ref_clk_in),
      .reset_in(reset_in),
      .we_in(mem_we),
      .addr_in(mem_addr),
      .wdata_in(mem_wdata),
      .rdata_out(mem_rd)
   );

   assign op = s_r.op;
   assign cin = s_r.flags[FLG_C];
   assign ex = s_r.st == ST_EXEC;
   assign apb_acc = psel_in & penable_in & ~s_r.pready;
   // Flat address straight from the register, no bank bits involved
   assign mem_addr = s_r.addr;

   // Decimal adjust corrections per nibble
   assign lo_adj = (s_r.acc[3:0] > BCD_LIMIT) | s_r.flags[FLG_AC];
   assign hi_adj = (s_r.acc[7:4] > BCD_LIMIT) | cin;
   assign bcd_corr = {hi_adj ? BCD_FIX : 4'h0, lo_adj ? BCD_FIX : 4'h0};
   assign bcd9 = {1'b0, s_r.acc} + {1'b0, bcd_corr};

   // Borrow chain kept one bit above the byte
   assign sub9 = {1'b0, s_r.acc} - {1'b0, mem_rd} - {8'h00, ~cin};
   assign sub5 = {1'b0, s_r.acc[3:0]} - {1'b0, mem_rd[3:0]} - {4'h0, ~cin};
   assign sub_ov = (s_r.acc[7] ^ mem_rd[7]) & (s_r.acc[7] ^ sub9[7]);

   // Result and flags of the operation in progress
   always_comb begin
      res = mem_rd;
      fl = s_r.flags;
      unique case (op)
         OP_EXT_INVERT_MEM, OP_EXT_INVERT_TO_ACC: begin
            res = ~mem_rd;
            fl[FLG_Z] = is_zero(res);
         end
         OP_EXT_BCD_ADJUST_TO_MEM: begin
            res = bcd9[7:0];
            fl[FLG_C] = cin | hi_adj | bcd9[8];
         end
         OP_EXT_DECREMENT_MEM, OP_EXT_DECREMENT_TO_ACC: begin
            res = mem_rd - 8'h01;
            fl[FLG_Z] = is_zero(res);
         end
         OP_EXT_INCREMENT_MEM, OP_EXT_INCREMENT_TO_ACC: begin
            res = mem_rd + 8'h01;
            fl[FLG_Z] = is_zero(res);
         end
         OP_EXT_MOVE_TO_ACC: begin
            res = mem_rd;
         end
         OP_EXT_MOVE_TO_MEM: begin
            res = s_r.acc;
         end
         OP_EXT_OR_TO_ACC, OP_EXT_OR_TO_MEM: begin
            res = s_r.acc | mem_rd;
            fl[FLG_Z] = is_zero(res);
         end
         OP_EXT_ROTATE_LEFT, OP_EXT_ROTATE_LEFT_TO_ACC: begin
            res = {mem_rd[6:0], mem_rd[7]};
         end
         OP_EXT_ROTATE_LEFT_THRU_CARRY,
         OP_EXT_ROTATE_LEFT_THRU_CARRY_TO_ACC: begin
            res = {mem_rd[6:0], cin};
            fl[FLG_C] = mem_rd[7];
         end
         OP_EXT_ROTATE_RIGHT, OP_EXT_ROTATE_RIGHT_TO_ACC: begin
            res = {mem_rd[0], mem_rd[7:1]};
         end
         OP_EXT_ROTATE_RIGHT_THRU_CARRY,
         OP_EXT_ROTATE_RIGHT_THRU_CARRY_TO_ACC: begin
            res = {cin, mem_rd[7:1]};
            fl[FLG_C] = mem_rd[0];
         end
         OP_EXT_SUB_BORROW_TO_ACC, OP_EXT_SUB_BORROW_TO_MEM: begin
            res = sub9[7:0];
            fl[FLG_C] = ~sub9[8];
            fl[FLG_AC] = ~sub5[4];
            fl[FLG_OV] = sub_ov;
            fl[FLG_SC] = sub_ov ^ sub9[7];
            fl[FLG_Z] = is_zero(sub9[7:0]);
            fl[FLG_CZ] = is_zero(sub9[7:0]) & s_r.flags[FLG_CZ];
         end
         default: begin
            res = mem_rd;
         end
      endcase
   end

   // Destination of the result
   always_comb begin
      unique case (op)
         OP_EXT_INVERT_MEM, OP_EXT_BCD_ADJUST_TO_MEM, OP_EXT_DECREMENT_MEM,
         OP_EXT_INCREMENT_MEM, OP_EXT_MOVE_TO_MEM, OP_EXT_OR_TO_MEM,
         OP_EXT_ROTATE_LEFT, OP_EXT_ROTATE_LEFT_THRU_CARRY,
         OP_EXT_ROTATE_RIGHT, OP_EXT_ROTATE_RIGHT_THRU_CARRY,
         OP_EXT_SUB_BORROW_TO_MEM: begin
            to_mem = 1'b1;
         end
         default: begin
            to_mem = 1'b0;
         end
      endcase
   end

   // Bus slave and sequencer
   always_comb begin
      s_nxt = s_r;
      s_nxt.pready = 1'b0;
      s_nxt.pslverr = 1'b0;
      mem_we = 1'b0;
      mem_wdata = pwdata_in[7:0];
      unique case (s_r.st)
         ST_IDLE: begin
            if (apb_acc) begin
               s_nxt.pready = 1'b1;
               s_nxt.prdata = '0;
               if (pwrite_in) begin
                  case (paddr_in)
                     OFS_ACC: s_nxt.acc = pwdata_in[7:0];
                     OFS_FLAGS: s_nxt.flags = pwdata_in[FLAGS_W-1:0];
                     OFS_MADDR: s_nxt.addr = pwdata_in[MEM_AW-1:0];
                     OFS_MDATA: mem_we = 1'b1;
                     OFS_CMD: begin
                        if (is_legal(pwdata_in[OP_W-1:0])) begin
                           s_nxt.op = pwdata_in[OP_W-1:0];
                           s_nxt.bad = 1'b0;
                           s_nxt.st = ST_FETCH;
                        end else begin
                           s_nxt.bad = 1'b1;
                        end
                     end
                     default: s_nxt.pslverr = 1'b1;
                  endcase
               end else begin
                  case (paddr_in)
                     OFS_ACC: s_nxt.prdata = 32'(s_r.acc);
                     OFS_FLAGS: s_nxt.prdata = 32'(s_r.flags);
                     OFS_MADDR: s_nxt.prdata = 32'(s_r.addr);
                     OFS_MDATA: begin
                        s_nxt.pready = 1'b0;
                        s_nxt.st = ST_RDWAIT;
                     end
                     OFS_CMD: begin
                        s_nxt.prdata = 32'(s_r.op);
                        s_nxt.prdata[CMD_BAD_BIT] = s_r.bad;
                     end
                     default: s_nxt.pslverr = 1'b1;
                  endcase
               end
            end
         end
         ST_RDWAIT: begin
            s_nxt.prdata = 32'(mem_rd);
            s_nxt.pready = 1'b1;
            s_nxt.st = ST_IDLE;
         end
         ST_FETCH: begin
            s_nxt.st = ST_EXEC;
         end
         ST_EXEC: begin
            mem_we = to_mem;
            mem_wdata = res;
            if (!to_mem) begin
               s_nxt.acc = res;
            end
            s_nxt.flags = fl;
            s_nxt.st = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         s_r <= '{st: ST_IDLE, acc: ACC_RST, flags: FLAGS_RST,
                  addr: MADDR_RST, op: OP_RST, bad: 1'b0, pready: 1'b0,
                  pslverr: 1'b0, prdata: '0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign prdata_out = s_r.prdata;
   assign pready_out = s_r.pready;
   assign pslverr_out = s_r.pslverr;

   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (reset_in);

   property p_flat_addr;
      ex |-> mem_addr == s_r.addr && $stable(s_r.addr);
   endproperty
   a_flat_addr: assert property (p_flat_addr)
      else $error("memory address differs from address register");

   property p_inv_mem;
      ex && op == OP_EXT_INVERT_MEM |-> mem_we && mem_wdata == ~mem_rd
         ##1 (s_r.flags & ~(6'h01 << FLG_Z)) ==
             ($past(s_r.flags) & ~(6'h01 << FLG_Z));
   endproperty
   a_inv_mem: assert property (p_inv_mem)
      else $error("invert memory result or flags wrong");

   property p_inv_acc;
      ex && op == OP_EXT_INVERT_TO_ACC |-> !mem_we
         ##1 s_r.acc == ~$past(mem_rd);
   endproperty
   a_inv_acc: assert property (p_inv_acc)
      else $error("invert to accumulator wrong");

   property p_bcd_nib;
      ex && op == OP_EXT_BCD_ADJUST_TO_MEM |->
         ((mem_wdata - s_r.acc) & 8'h0f) ==
            ((s_r.acc[3:0] > 4'h9 || s_r.flags[FLG_AC]) ? 8'h06 : 8'h00)
         && ((mem_wdata - s_r.acc) & 8'hf0) ==
            ((s_r.acc[7:4] > 4'h9 || cin) ? 8'h60 : 8'h00);
   endproperty
   a_bcd_nib: assert property (p_bcd_nib)
      else $error("decimal adjust nibble correction wrong");

   property p_bcd_mem;
      ex && op == OP_EXT_BCD_ADJUST_TO_MEM |-> mem_we
         && (mem_wdata - s_r.acc) inside {8'h00, 8'h06, 8'h60, 8'h66}
         ##1 $stable(s_r.acc);
   endproperty
   a_bcd_mem: assert property (p_bcd_mem)
      else $error("decimal adjust did not go to memory");

   property p_bcd_flags;
      ex && op == OP_EXT_BCD_ADJUST_TO_MEM |=>
         (s_r.flags & ~C_MASK) == ($past(s_r.flags) & ~C_MASK)
         && (!$past(cin) || s_r.flags[FLG_C])
         && ($past(s_r.acc) < 8'ha0 || s_r.flags[FLG_C]);
   endproperty
   a_bcd_flags: assert property (p_bcd_flags)
      else $error("decimal adjust carry or other flags wrong");

   property p_dec_mem;
      ex && op == OP_EXT_DECREMENT_MEM |->
         mem_we && mem_wdata == mem_rd - 8'h01;
   endproperty
   a_dec_mem: assert property (p_dec_mem)
      else $error("decrement memory wrong");

   property p_inc_acc;
      ex && op == OP_EXT_INCREMENT_TO_ACC |-> !mem_we
         ##1 s_r.acc == $past(mem_rd) + 8'h01;
   endproperty
   a_inc_acc: assert property (p_inc_acc)
      else $error("increment to accumulator wrong");

   property p_mov_acc;
      ex && op == OP_EXT_MOVE_TO_ACC |-> !mem_we
         ##1 s_r.acc == $past(mem_rd) && $stable(s_r.flags);
   endproperty
   a_mov_acc: assert property (p_mov_acc)
      else $error("move to accumulator wrong");

   property p_mov_mem;
      ex && op == OP_EXT_MOVE_TO_MEM |-> mem_we && mem_wdata == s_r.acc
         ##1 $stable(s_r.flags);
   endproperty
   a_mov_mem: assert property (p_mov_mem)
      else $error("move to memory wrong");

   property p_or_mem;
      ex && op == OP_EXT_OR_TO_MEM |-> mem_we
         && mem_wdata == (s_r.acc | mem_rd) ##1 $stable(s_r.acc);
   endproperty
   a_or_mem: assert property (p_or_mem)
      else $error("OR to memory wrong");

   property p_rol_mem;
      ex && op == OP_EXT_ROTATE_LEFT |-> mem_we
         && mem_wdata == {mem_rd[6:0], mem_rd[7]} ##1 $stable(s_r.flags);
   endproperty
   a_rol_mem: assert property (p_rol_mem)
      else $error("rotate left wrong");

   property p_rlc_acc;
      ex && op == OP_EXT_ROTATE_LEFT_THRU_CARRY_TO_ACC |-> !mem_we
         ##1 s_r.acc == {$past(mem_rd[6:0]), $past(cin)}
         && s_r.flags[FLG_C] == $past(mem_rd[7]);
   endproperty
   a_rlc_acc: assert property (p_rlc_acc)
      else $error("rotate left through carry wrong");

   property p_ror_acc;
      ex && op == OP_EXT_ROTATE_RIGHT_TO_ACC |-> !mem_we
         ##1 s_r.acc == {$past(mem_rd[0]), $past(mem_rd[7:1])}
         && $stable(s_r.flags);
   endproperty
   a_ror_acc: assert property (p_ror_acc)
      else $error("rotate right to accumulator wrong");

   property p_rrc_mem;
      ex && op == OP_EXT_ROTATE_RIGHT_THRU_CARRY |-> mem_we
         && mem_wdata == {cin, mem_rd[7:1]}
         ##1 s_r.flags[FLG_C] == $past(mem_rd[0]);
   endproperty
   a_rrc_mem: assert property (p_rrc_mem)
      else $error("rotate right through carry wrong");

   property p_sbc_acc;
      ex && op == OP_EXT_SUB_BORROW_TO_ACC |-> !mem_we ##1
         s_r.acc == $past(s_r.acc) - $past(mem_rd) - {7'h00, !$past(cin)};
   endproperty
   a_sbc_acc: assert property (p_sbc_acc)
      else $error("subtract with borrow to accumulator wrong");

   property p_sbc_mem;
      ex && op == OP_EXT_SUB_BORROW_TO_MEM |-> mem_we
         && mem_wdata == s_r.acc - mem_rd - {7'h00, !cin}
         ##1 $stable(s_r.acc);
   endproperty
   a_sbc_mem: assert property (p_sbc_mem)
      else $error("subtract with borrow to memory wrong");

   property p_sbc_c;
      ex && (op == OP_EXT_SUB_BORROW_TO_ACC || op == OP_EXT_SUB_BORROW_TO_MEM)
         |=> s_r.flags[FLG_C] == ($past(s_r.acc) > $past(mem_rd)
            || ($past(s_r.acc) == $past(mem_rd) && $past(cin)));
   endproperty
   a_sbc_c: assert property (p_sbc_c)
      else $error("borrow carry wrong");

   property p_zero;
      ex && (op == OP_EXT_OR_TO_ACC || op == OP_EXT_DECREMENT_TO_ACC)
         |=> s_r.flags[FLG_Z] == (s_r.acc == 8'h00);
   endproperty
   a_zero: assert property (p_zero)
      else $error("zero flag does not match result");

   property p_wrap;
      ex && op == OP_EXT_INCREMENT_MEM && mem_rd == 8'hff |->
         mem_wdata == 8'h00 ##1 s_r.flags[FLG_Z];
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("increment did not wrap within a byte");
endmodule
